// ===== verification/keypad_mode_controller_tb.sv
/*
  self-checking bench: register rows, reset, key and fault cases.
  assumes short debounce and scan counts and the operator model.
*/
`timescale 1ns/1ns
module keypad_mode_controller_tb;
  import kmc_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] w, r; logic [1:0] e;} kmc_row_s;
  logic        core_clk, rst, fault_pin, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, run_lamp, program_indicator, motor_enable;
  logic        run_key_enable_lamp, pot_enable_lamp, hertz_lamp, ampere_lamp;
  logic        run_fwd, run_rev, decel_stop, trip_clear, nv_wr;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [6:0]  seg;
  logic [3:0]  digit_sel;
  logic [4:0]  nv_addr, pulses;
  logic [15:0] nv_data;
  logic [5:0]  keys;
  int          n_fail, n_compared, cnt[5], base[5];
  kmc_row_s    rows[5] = '{'{A_CTRL, 32'h27, 32'h27, RESP_OKAY},
                           '{A_RUN_EDIT, 32'hffff_ffff, 32'hffff_ffff, RESP_OKAY},
                           '{A_MONITOR, 32'h1234, 32'h1234, RESP_OKAY},
                           '{8'hfc, 32'habcd_0001, 32'h1, RESP_OKAY},
                           '{8'h40, 32'h1, 32'h0, RESP_SLVERR}};
  kmc_keypad_ctrl #(.DEBOUNCE_CYCLES(4), .SCAN_CYCLES(4)) dut (
    .core_clk, .rst, .ce(1'b1), .key_run_pin(keys[K_RUN]), .key_stop_pin(keys[K_STOP]),
    .key_func_pin(keys[K_FUNC]), .key_up_pin(keys[K_UP]), .key_down_pin(keys[K_DOWN]),
    .commit_key_pin(keys[K_COMMIT]), .fault_pin, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .run_lamp,
    .program_indicator, .run_key_enable_lamp, .pot_enable_lamp, .hertz_lamp, .ampere_lamp,
    .seg, .digit_sel, .run_fwd, .run_rev, .decel_stop, .trip_clear, .motor_enable, .nv_wr,
    .nv_addr, .nv_data);
  kmc_operator op (.core_clk, .keys);
  // pulse counters, one per command output
  assign pulses = {nv_wr, trip_clear, decel_stop, run_rev, run_fwd};
  always @(posedge core_clk)
    foreach (cnt[i]) cnt[i] <= cnt[i] + pulses[i];
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #2_000_000;
    n_fail++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge core_clk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, fault_pin, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h10;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      chk("bresp", rows[i].e, rs);
      rdr(rows[i].a);
      chk("rresp", rows[i].e, rs);
      chk("rdata", rows[i].r, rd);
    end
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rdr(A_CTRL);
    chk("ctrl", CTRL_RST, rd);
    chk("hertz", 1'b1, hertz_lamp);
    chk("prog_lamp", 1'b0, program_indicator);
    do @(posedge core_clk); while (digit_sel !== 4'h8);
    chk("seg_d", 32'h5e, seg);
    base = cnt;
    op.press(K_RUN);
    chk("run_fwd", 1, cnt[0] - base[0]);
    chk("run_lamp", 1'b1, run_lamp);
    chk("rke_lamp", 1'b0, run_key_enable_lamp);
    op.press(K_UP);
    chk("prog_lamp", 1'b1, program_indicator);
    op.press(K_FUNC);
    op.press(K_FUNC);
    op.press(K_COMMIT);
    op.press(K_UP);
    op.press(K_COMMIT);
    chk("nv_wr", 0, cnt[4] - base[4]);
    wr(A_RUN_EDIT, 32'hffff_ffff);
    op.press(K_UP);
    op.press(K_COMMIT);
    chk("nv_wr", 1, cnt[4] - base[4]);
    chk("nv_data", 16'h0001, nv_data);
    chk("nv_addr", 32'h0, nv_addr);
    op.press(K_STOP);
    chk("decel", 1, cnt[2] - base[2]);
    chk("run_lamp", 1'b0, run_lamp);
    wr(A_CTRL, 32'h7);
    chk("pot_lamp", 1'b1, pot_enable_lamp);
    op.press(K_RUN);
    chk("run_rev", 1, cnt[1] - base[1]);
    fault_pin <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("run_lamp", 1'b0, run_lamp);
    chk("motor", 1'b0, motor_enable);
    op.press(K_RUN);
    chk("run_rev", 1, cnt[1] - base[1]);
    chk("rke_lamp", 1'b0, run_key_enable_lamp);
    fault_pin <= 1'b0;
    op.press(K_STOP);
    chk("trip_clr", 1, cnt[3] - base[3]);
    chk("decel", 1, cnt[2] - base[2]);
    chk("rke_lamp", 1'b1, run_key_enable_lamp);
    chk("units", 1'b1, hertz_lamp ^ ampere_lamp);
    chk("digits", 1, $countones(digit_sel));
    do @(posedge core_clk); while (digit_sel !== 4'h8);
    chk("seg_f", 32'h71, seg);
    // lock all edits, then try an edit and a store from the value view
    wr(A_CTRL, 32'h14);
    op.press(K_FUNC);
    op.press(K_UP);
    op.press(K_COMMIT);
    chk("nv_wr", 1, cnt[4] - base[4]);
    end_of_test();
  end
endmodule

// ===== verification/kmc_operator.sv
/*
  operator model: presses and releases one key at a time.
  assumes the bench clock; each key is held well past debounce.
*/
`timescale 1ns/1ns
module kmc_operator (
  input  wire logic       core_clk,
  output logic      [5:0] keys
);
  initial keys = 6'h00;
  // full press then full release; stop is also the way out of trip
  task automatic press(input int k);
    @(posedge core_clk);
    keys[k] <= 1'b1;
    repeat (20) @(posedge core_clk);
    keys[k] <= 1'b0;
    repeat (20) @(posedge core_clk);
  endtask
endmodule

// ===== verilog/kmc_keypad_ctrl.sv
/*
  keypad mode controller: debounced keys, run/stop, program/monitor
  and trip modes, navigation, edit gating, store, seven-segment scan,
  lamps and an AXI4-Lite register slave.
  assumes key and fault pins are asynchronous, active high, and that
  the bus runs on core_clk.
*/
`timescale 1ns/1ns
module kmc_keypad_ctrl #(
  parameter int DEBOUNCE_CYCLES = kmc_pkg::DEBOUNCE_CYC,
  parameter int SCAN_CYCLES     = kmc_pkg::SCAN_CYC
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   key_run_pin,
  input  wire logic                   key_stop_pin,
  input  wire logic                   key_func_pin,
  input  wire logic                   key_up_pin,
  input  wire logic                   key_down_pin,
  input  wire logic                   commit_key_pin,
  input  wire logic                   fault_pin,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [kmc_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [kmc_pkg::AW-1:0] s_axi_araddr,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        run_lamp,
  output logic                        program_indicator,
  output logic                        run_key_enable_lamp,
  output logic                        pot_enable_lamp,
  output logic                        hertz_lamp,
  output logic                        ampere_lamp,
  output logic [6:0]                  seg,
  output logic [3:0]                  digit_sel,
  output logic                        run_fwd,
  output logic                        run_rev,
  output logic                        decel_stop,
  output logic                        trip_clear,
  output logic                        motor_enable,
  output logic                        nv_wr,
  output logic [4:0]                  nv_addr,
  output logic [kmc_pkg::VAL_W-1:0]   nv_data
);
  import kmc_pkg::*;

  typedef struct packed {
    logic [NKEY:0]                sync1;
    logic [NKEY:0]                sync2;
    logic [NKEY-1:0][DB_W-1:0]    dbc;
    logic [NKEY-1:0]              stable;
    logic                         running;
    logic                         trip;
    kmc_nav_e                     nav;
    logic [2:0]                   grp;
    logic [4:0]                   idx;
    logic [VAL_W-1:0]             edit;
    logic                         edited;
    logic [31:0]                  ctrl;
    logic [31:0]                  run_edit;
    logic [VAL_W-1:0]             monitor;
    logic [NPARAM-1:0][VAL_W-1:0] ptab;
    logic [SC_W-1:0]              scan_cnt;
    logic [1:0]                   digit;
    logic                         run_lamp;
    logic                         prog_lamp;
    logic                         rke_lamp;
    logic                         pot_lamp;
    logic                         hz_lamp;
    logic                         amp_lamp;
    logic [6:0]                   seg;
    logic [3:0]                   dsel;
    logic                         run_fwd;
    logic                         run_rev;
    logic                         decel_stop;
    logic                         trip_clear;
    logic                         motor_en;
    logic                         nv_wr;
    logic [4:0]                   nv_addr;
    logic [VAL_W-1:0]             nv_data;
    logic                         aw_held;
    logic [AW-1:0]                aw_addr;
    logic                         w_held;
    logic [31:0]                  w_data;
    logic [3:0]                   w_strb;
    logic                         awready;
    logic                         wready;
    logic                         bvalid;
    logic [1:0]                   bresp;
    logic                         arready;
    logic                         rvalid;
    logic [31:0]                  rdata;
    logic [1:0]                   rresp;
  } kmc_state_s;

  localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_CYCLES - 1);
  localparam logic [SC_W-1:0] SC_LAST = SC_W'(SCAN_CYCLES - 1);

  kmc_state_s             s;
  kmc_state_s             next_s;
  logic [NKEY-1:0]        press;
  logic                   fault;
  logic                   run_en;
  logic                   allowed;
  logic                   prog;
  logic [1:0]             lock;
  logic [3:0][6:0]        glyph;
  logic [5:0]             num;

  function automatic logic [6:0] hex_glyph(input logic [3:0] h);
    case (h)
      4'h0: hex_glyph = 7'h3f;
      4'h1: hex_glyph = 7'h06;
      4'h2: hex_glyph = 7'h5b;
      4'h3: hex_glyph = 7'h4f;
      4'h4: hex_glyph = 7'h66;
      4'h5: hex_glyph = 7'h6d;
      4'h6: hex_glyph = 7'h7d;
      4'h7: hex_glyph = 7'h07;
      4'h8: hex_glyph = 7'h7f;
      4'h9: hex_glyph = 7'h6f;
      4'ha: hex_glyph = 7'h77;
      4'hb: hex_glyph = 7'h7c;
      4'hc: hex_glyph = 7'h39;
      4'hd: hex_glyph = 7'h5e;
      4'he: hex_glyph = 7'h79;
      default: hex_glyph = 7'h71;
    endcase
  endfunction

  // groups in order d F A b C H; b and d use the lower-case forms
  function automatic logic [6:0] grp_glyph(input logic [2:0] g);
    case (g)
      3'h0: grp_glyph = hex_glyph(4'hd);
      3'h1: grp_glyph = hex_glyph(4'hf);
      3'h2: grp_glyph = hex_glyph(4'ha);
      3'h3: grp_glyph = hex_glyph(4'hb);
      3'h4: grp_glyph = hex_glyph(4'hc);
      default: grp_glyph = GLYPH_H;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] b);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        merge[8*i +: 8] = d[8*i +: 8];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    press = '0;
    next_s.sync1 = {fault_pin, commit_key_pin, key_down_pin, key_up_pin,
                    key_func_pin, key_stop_pin, key_run_pin};
    next_s.sync2 = s.sync1;
    fault = s.sync2[NKEY];
    for (int k = 0; k < NKEY; k++) begin
      if (s.sync2[k] == s.stable[k]) begin
        next_s.dbc[k] = '0;
      end else if (s.dbc[k] == DB_LAST) begin
        next_s.dbc[k] = '0;
        next_s.stable[k] = s.sync2[k];
        press[k] = s.sync2[k];
      end else begin
        next_s.dbc[k] = s.dbc[k] + 1'b1;
      end
    end
    next_s.run_fwd = 1'b0;
    next_s.run_rev = 1'b0;
    next_s.decel_stop = 1'b0;
    next_s.trip_clear = 1'b0;
    next_s.nv_wr = 1'b0;

    // bus write applied first so a store in the same cycle wins
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      if (s.aw_addr >= A_TABLE) begin
        next_s.ptab[s.aw_addr[6:2]] = VAL_W'(merge({16'h0, s.ptab[s.aw_addr[6:2]]},
                                                    s.w_data, s.w_strb));
      end else begin
        case (s.aw_addr[7:2])
          A_CTRL[7:2]:     next_s.ctrl = merge(s.ctrl, s.w_data, s.w_strb);
          A_RUN_EDIT[7:2]: next_s.run_edit = merge(s.run_edit, s.w_data, s.w_strb);
          A_MONITOR[7:2]:  next_s.monitor = VAL_W'(merge({16'h0, s.monitor},
                                                   s.w_data, s.w_strb));
          A_STATUS[7:2], A_COMMIT[7:2]: next_s.bresp = RESP_OKAY;
          default:         next_s.bresp = RESP_SLVERR;
        endcase
      end
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.awready && s_axi_awvalid) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_held = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    next_s.awready = !next_s.aw_held;
    next_s.wready = !next_s.w_held;
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
    if (s.arready && s_axi_arvalid) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = '0;
      if (s_axi_araddr >= A_TABLE) begin
        next_s.rdata = {16'h0, s.ptab[s_axi_araddr[6:2]]};
      end else begin
        case (s_axi_araddr[7:2])
          A_CTRL[7:2]:     next_s.rdata = s.ctrl;
          A_STATUS[7:2]:   next_s.rdata = {18'h0, s.edited, s.idx, s.grp, s.nav,
                                           s.grp != GRP_MON, s.trip, s.running};
          A_RUN_EDIT[7:2]: next_s.rdata = s.run_edit;
          A_MONITOR[7:2]:  next_s.rdata = {16'h0, s.monitor};
          A_COMMIT[7:2]:   next_s.rdata = {11'h0, s.nv_addr, s.nv_data};
          default:         next_s.rresp = RESP_SLVERR;
        endcase
      end
    end

    // run/stop and trip; program/monitor follows the group alone
    lock = s.ctrl[CTRL_LOCK +: 2];
    prog = s.grp != GRP_MON;
    run_en = s.ctrl[CTRL_KEYRUN] && !s.trip && !s.running;
    allowed = (lock != LOCK_ALL) &&
              (!s.running || (s.run_edit[s.idx] && lock != LOCK_RUN));
    if (press[K_RUN] && run_en) begin
      next_s.running = 1'b1;
      next_s.run_fwd = !s.ctrl[CTRL_DIR];
      next_s.run_rev = s.ctrl[CTRL_DIR];
    end
    if (press[K_STOP]) begin
      if (s.trip) begin
        next_s.trip = 1'b0;
        next_s.trip_clear = 1'b1;
      end else if (s.running) begin
        next_s.running = 1'b0;
        next_s.decel_stop = 1'b1;
      end
    end
    if (fault) begin
      next_s.trip = 1'b1;
      next_s.running = 1'b0;
      next_s.trip_clear = 1'b0;
      next_s.run_fwd = 1'b0;
      next_s.run_rev = 1'b0;
    end

    // navigation: group list, parameter list, value view
    case (s.nav)
      NAV_GROUP: begin
        if (press[K_FUNC]) begin
          next_s.nav = NAV_LIST;
          next_s.idx = '0;
        end else if (press[K_UP]) begin
          next_s.grp = (s.grp == GRP_LAST) ? 3'h0 : 3'(s.grp + 3'h1);
        end else if (press[K_DOWN]) begin
          next_s.grp = (s.grp == 3'h0) ? GRP_LAST : 3'(s.grp - 3'h1);
        end
      end
      NAV_LIST: begin
        if (press[K_FUNC]) begin
          next_s.nav = NAV_VALUE;
          next_s.edit = s.ptab[s.idx];
          next_s.edited = 1'b0;
        end else if (press[K_COMMIT]) begin
          next_s.nav = NAV_GROUP;
        end else if (press[K_UP]) begin
          next_s.idx = s.idx + 5'h1;
        end else if (press[K_DOWN]) begin
          next_s.idx = s.idx - 5'h1;
        end
      end
      NAV_VALUE: begin
        if (press[K_FUNC]) begin
          next_s.nav = NAV_LIST;
          next_s.edited = 1'b0;
        end else if (press[K_UP] && prog && allowed) begin
          next_s.edit = s.edit + 16'h1;
          next_s.edited = 1'b1;
        end else if (press[K_DOWN] && prog && allowed) begin
          next_s.edit = s.edit - 16'h1;
          next_s.edited = 1'b1;
        end else if (press[K_COMMIT] && prog && s.edited && allowed) begin
          next_s.ptab[s.idx] = s.edit;
          next_s.nv_wr = 1'b1;
          next_s.nv_addr = s.idx;
          next_s.nv_data = s.edit;
          next_s.edited = 1'b0;
          next_s.nav = NAV_LIST;
        end
      end
      default: next_s.nav = NAV_GROUP;
    endcase

    // display: four scanned digits
    num = 6'({1'b0, s.idx} + 6'h1);
    glyph = {4{GLYPH_BLANK}};
    case (s.nav)
      NAV_GROUP: glyph[3] = grp_glyph(s.grp);
      NAV_LIST: begin
        glyph[3] = grp_glyph(s.grp);
        glyph[1] = hex_glyph(4'(num / 6'd10));
        glyph[0] = hex_glyph(4'(num % 6'd10));
      end
      default: begin
        for (int d = 0; d < 4; d++) begin
          glyph[d] = hex_glyph(prog ? s.edit[4*d +: 4] : s.monitor[4*d +: 4]);
        end
      end
    endcase
    if (s.scan_cnt == SC_LAST) begin
      next_s.scan_cnt = '0;
      next_s.digit = s.digit + 2'h1;
    end else begin
      next_s.scan_cnt = s.scan_cnt + 1'b1;
    end
    next_s.seg = glyph[s.digit];
    next_s.dsel = 4'h1 << s.digit;

    // lamps follow the state being registered
    next_s.motor_en = next_s.running && !next_s.trip;
    next_s.run_lamp = next_s.running && !next_s.trip;
    next_s.prog_lamp = next_s.grp != GRP_MON;
    next_s.rke_lamp = next_s.ctrl[CTRL_KEYRUN] && !next_s.trip && !next_s.running;
    next_s.pot_lamp = next_s.ctrl[CTRL_POT];
    next_s.amp_lamp = next_s.grp == GRP_MON && next_s.idx == IDX_AMPS;
    next_s.hz_lamp = !next_s.amp_lamp;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // keypad comes up idle at the group list; no edit in progress
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.hz_lamp <= 1'b1;
      s.rke_lamp <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign run_lamp = s.run_lamp;
  assign program_indicator = s.prog_lamp;
  assign run_key_enable_lamp = s.rke_lamp;
  assign pot_enable_lamp = s.pot_lamp;
  assign hertz_lamp = s.hz_lamp;
  assign ampere_lamp = s.amp_lamp;
  assign seg = s.seg;
  assign digit_sel = s.dsel;
  assign run_fwd = s.run_fwd;
  assign run_rev = s.run_rev;
  assign decel_stop = s.decel_stop;
  assign trip_clear = s.trip_clear;
  assign motor_enable = s.motor_en;
  assign nv_wr = s.nv_wr;
  assign nv_addr = s.nv_addr;
  assign nv_data = s.nv_data;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_run_press;
    ce && press[K_RUN] && run_en;
  endsequence
  sequence s_run_cmd;
    (run_fwd ^ run_rev) && run_rev == s.ctrl[CTRL_DIR] && s.running;
  endsequence

  a_run_cmd_dir: assert property (s_run_press ##0 !fault |=> s_run_cmd)
    else $error("run key gave no run command in the set direction");
  a_run_lamp_out: assert property (run_lamp == motor_enable && !(s.trip && run_lamp))
    else $error("run lamp disagrees with motor output or trip");
  a_trip_blocks_run: assert property (ce && s.trip && press[K_RUN] |=>
                                      !run_fwd && !run_rev && !s.running)
    else $error("run accepted while tripped");
  a_fault_trips: assert property (ce && fault |=> s.trip && !s.running ##1 !motor_enable)
    else $error("fault did not trip and drop output");
  a_stop_decel: assert property (ce && press[K_STOP] && s.running && !s.trip && !fault
                                 |=> decel_stop && !s.running ##1 !decel_stop)
    else $error("stop key did not ramp down");
  a_trip_clear: assert property (ce && press[K_STOP] && s.trip && !fault
                                 |=> trip_clear && !s.trip)
    else $error("stop key did not clear trip");
  a_unit_single: assert property (hertz_lamp != ampere_lamp)
    else $error("unit lamps not exclusive");
  a_store_cause: assert property ($rose(nv_wr) |-> $past(press[K_COMMIT]) && $past(ce))
    else $error("memory written without store key");
  a_run_edit_gate: assert property (ce && s.nav == NAV_VALUE && s.running &&
                                    !s.run_edit[s.idx] && (press[K_UP] || press[K_DOWN])
                                    |=> s.edit == $past(s.edit))
    else $error("edit accepted while running");
  // lamp must track the group both ways, also when up/down wraps back to monitor
  a_prog_lamp: assert property (program_indicator == (s.grp != GRP_MON))
    else $error("program lamp wrong");
  a_key_pulse: assert property (ce && press[K_FUNC] |=> !press[K_FUNC] [*2])
    else $error("key press repeated");
endmodule

// ===== verilog/kmc_pkg.sv
/*
  constants for the keypad mode controller: timing, register map,
  control field positions, lock codes and navigation states.
  assumes a 10 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
package kmc_pkg;
  localparam int          CLK_HZ       = 10_000_000;
  localparam int          DEBOUNCE_US  = 10_000;
  localparam int          DEBOUNCE_CYC = CLK_HZ / 1_000_000 * DEBOUNCE_US;
  localparam int          SCAN_US      = 1_000;
  localparam int          SCAN_CYC     = CLK_HZ / 1_000_000 * SCAN_US;
  localparam int          DB_W         = 17;
  localparam int          SC_W         = 14;
  localparam int          NKEY         = 6;
  localparam int          K_RUN        = 0;
  localparam int          K_STOP       = 1;
  localparam int          K_FUNC       = 2;
  localparam int          K_UP         = 3;
  localparam int          K_DOWN       = 4;
  localparam int          K_COMMIT     = 5;
  localparam int          AW           = 8;
  localparam logic [7:0]  A_CTRL       = 8'h00;
  localparam logic [7:0]  A_STATUS     = 8'h04;
  localparam logic [7:0]  A_RUN_EDIT   = 8'h08;
  localparam logic [7:0]  A_MONITOR    = 8'h0c;
  localparam logic [7:0]  A_COMMIT     = 8'h10;
  localparam logic [7:0]  A_TABLE      = 8'h80;
  localparam int          CTRL_DIR     = 0;
  localparam int          CTRL_POT     = 1;
  localparam int          CTRL_KEYRUN  = 2;
  localparam int          CTRL_LOCK    = 4;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0004;
  localparam logic [1:0]  LOCK_NONE    = 2'h0;
  localparam logic [1:0]  LOCK_ALL     = 2'h1;
  localparam logic [1:0]  LOCK_RUN     = 2'h2;
  localparam int          NPARAM       = 32;
  localparam int          VAL_W        = 16;
  localparam logic [2:0]  GRP_MON      = 3'h0;
  localparam logic [2:0]  GRP_LAST     = 3'h5;
  localparam logic [4:0]  IDX_AMPS     = 5'h01;
  localparam logic [6:0]  GLYPH_H      = 7'h76;
  localparam logic [6:0]  GLYPH_BLANK  = 7'h00;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  typedef enum logic [1:0] {NAV_GROUP, NAV_LIST, NAV_VALUE} kmc_nav_e;
endpackage
